// *** ofc_freq_regs.sv ***
// Oscillator frequency configuration register bank
// Operation
// - 38-bit multiplier: bits 37:32 in register 8 low six, bytes in 9 to 12.
// - Register 8 bits 7:6 hold the output divider code low two bits.
// - Output divider code is ratio minus one; zero is 1, all ones is 128.
// - Ratios 1 and even to 128 accepted; odd ratios above one rounded up.
// - High-speed code 0,1,2,3,5,7 gives 4,5,6,7,9,11; 4 and 6 unused.
// - Register 13: alt speed code and divider top; register 14: divider low, multiplier top.
// - Alternate output divider uses the same encoding and odd rounding.
// - New-frequency flag, control bit 6, clears itself once the frequency applies.
// - Control bit 5 freezes the applied multiplier during byte writes.
// - Bit 4 at offset 137 holds the synthesizer while configuration changes.
`timescale 1ns/1ps
`include "ofc_consts.svh"

module ofc_freq_regs (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_we_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_re_i,
   output logic      [7:0]  reg_rdata_o,
   // Oscillator core
   output logic      [37:0] multiplier_word_o,
   output logic      [3:0]  high_speed_ratio_o,
   output logic      [7:0]  output_ratio_o,
   output logic      [3:0]  alt_high_speed_ratio_o,
   output logic      [7:0]  alt_output_ratio_o,
   output logic      [5:0]  alt_multiplier_top_o,
   output logic             new_frequency_flag_o,
   output logic             synthesizer_hold_o
);

   // ==========================================================
   // State
   ofc_pkg::ofc_state_type state_reg;
   ofc_pkg::ofc_state_type state_next;

   logic [37:0] mult_staged;
   logic [3:0]  hs_ratio_dec;
   logic        hs_legal_dec;
   logic [7:0]  out_ratio_dec;
   logic [3:0]  alt_hs_ratio_dec;
   logic        alt_hs_legal_dec;
   logic [7:0]  alt_out_ratio_dec;
   logic        apply;

   // ==========================================================
   // Byte index of a configuration offset
   function automatic logic [2:0] cfg_index(input logic [7:0] addr);
      logic [7:0] diff;
      diff = addr - `OFC_OFF_DIV_HIGH;
      return diff[2:0];
   endfunction

   function automatic logic is_cfg(input logic [7:0] addr);
      return addr >= `OFC_OFF_DIV_HIGH && addr <= `OFC_OFF_ALT_LOW;
   endfunction

   // ==========================================================
   // Field views of the stored bytes
   assign mult_staged = {state_reg.cfg[cfg_index(`OFC_OFF_DIV_LOW)][5:0],
                         state_reg.cfg[cfg_index(`OFC_OFF_RATIO_31_24)],
                         state_reg.cfg[cfg_index(`OFC_OFF_RATIO_23_16)],
                         state_reg.cfg[cfg_index(`OFC_OFF_RATIO_15_8)],
                         state_reg.cfg[cfg_index(`OFC_OFF_RATIO_7_0)]};

   ofc_divider_decode u_primary_decode (
      .hs_code_i   (state_reg.cfg[cfg_index(`OFC_OFF_DIV_HIGH)][7:5]),
      .out_code_i  ({state_reg.cfg[cfg_index(`OFC_OFF_DIV_HIGH)][4:0],
                     state_reg.cfg[cfg_index(`OFC_OFF_DIV_LOW)][7:6]}),
      .hs_ratio_o  (hs_ratio_dec),
      .hs_legal_o  (hs_legal_dec),
      .out_ratio_o (out_ratio_dec)
   );

   ofc_divider_decode u_alt_decode (
      .hs_code_i   (state_reg.cfg[cfg_index(`OFC_OFF_ALT_SPEED)][7:5]),
      .out_code_i  ({state_reg.cfg[cfg_index(`OFC_OFF_ALT_SPEED)][4:0],
                     state_reg.cfg[cfg_index(`OFC_OFF_ALT_LOW)][7:6]}),
      .hs_ratio_o  (alt_hs_ratio_dec),
      .hs_legal_o  (alt_hs_legal_dec),
      .out_ratio_o (alt_out_ratio_dec)
   );

   // ==========================================================
   // Next state
   assign apply = state_reg.new_freq && !state_reg.hold;

   always_comb begin
      state_next = state_reg;
      // Register writes
      if (reg_we_i) begin
         if (is_cfg(reg_addr_i)) begin
            state_next.cfg[cfg_index(reg_addr_i)] = reg_wdata_i;
         end else if (reg_addr_i == `OFC_OFF_CONTROL) begin
            state_next.freeze_mult = reg_wdata_i[`OFC_BIT_FREEZE_MULT];
         end else if (reg_addr_i == `OFC_OFF_HOLD) begin
            state_next.hold = reg_wdata_i[`OFC_BIT_HOLD];
         end
      end
      // Applying a new configuration
      if (apply) begin
         state_next.new_freq      = 1'b0;
         state_next.mult_applied  = mult_staged;
         state_next.out_ratio     = out_ratio_dec;
         state_next.alt_out_ratio = alt_out_ratio_dec;
         if (hs_legal_dec) begin
            state_next.hs_ratio = hs_ratio_dec;
         end
         if (alt_hs_legal_dec) begin
            state_next.alt_hs_ratio = alt_hs_ratio_dec;
         end
      end else if (!state_reg.freeze_mult && !state_reg.hold) begin
         state_next.mult_applied = mult_staged;
      end
      // A host setting the flag wins over the clear
      if (reg_we_i && reg_addr_i == `OFC_OFF_CONTROL
          && reg_wdata_i[`OFC_BIT_NEW_FREQ]) begin
         state_next.new_freq = 1'b1;
      end
      // Read data
      if (reg_re_i) begin
         state_next.rdata = `OFC_RST_BYTE;
         if (is_cfg(reg_addr_i)) begin
            state_next.rdata = state_reg.cfg[cfg_index(reg_addr_i)];
         end else if (reg_addr_i == `OFC_OFF_CONTROL) begin
            state_next.rdata[`OFC_BIT_NEW_FREQ]    = state_reg.new_freq;
            state_next.rdata[`OFC_BIT_FREEZE_MULT] = state_reg.freeze_mult;
         end else if (reg_addr_i == `OFC_OFF_HOLD) begin
            state_next.rdata[`OFC_BIT_HOLD] = state_reg.hold;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_reg.cfg           <= {ofc_pkg::CFG_BYTES{`OFC_RST_BYTE}};
         state_reg.new_freq      <= 1'b0;
         state_reg.freeze_mult   <= 1'b0;
         state_reg.hold          <= 1'b0;
         state_reg.mult_applied  <= `OFC_RST_MULT;
         state_reg.hs_ratio      <= `OFC_RST_HS_RATIO;
         state_reg.out_ratio     <= `OFC_RST_OUT_RATIO;
         state_reg.alt_hs_ratio  <= `OFC_RST_HS_RATIO;
         state_reg.alt_out_ratio <= `OFC_RST_OUT_RATIO;
         state_reg.rdata         <= `OFC_RST_BYTE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata_o            = state_reg.rdata;
   assign multiplier_word_o      = state_reg.mult_applied;
   assign high_speed_ratio_o     = state_reg.hs_ratio;
   assign output_ratio_o         = state_reg.out_ratio;
   assign alt_high_speed_ratio_o = state_reg.alt_hs_ratio;
   assign alt_output_ratio_o     = state_reg.alt_out_ratio;
   assign alt_multiplier_top_o   = state_reg.cfg[cfg_index(`OFC_OFF_ALT_LOW)][5:0];
   assign new_frequency_flag_o   = state_reg.new_freq;
   assign synthesizer_hold_o     = state_reg.hold;

   // ==========================================================
   // Assertions
   a_ratio_top_byte: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      reg_we_i && reg_addr_i == `OFC_OFF_DIV_LOW
      |=> mult_staged[37:32] == $past(reg_wdata_i[5:0]))
      else $error("Multiplier top bits not taken from offset 8");

   a_ratio_low_byte: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      reg_we_i && reg_addr_i == `OFC_OFF_RATIO_7_0
      |=> mult_staged[7:0] == $past(reg_wdata_i))
      else $error("Multiplier low byte not taken from offset 12");

   a_divider_even: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      output_ratio_o == 8'h01 || (!output_ratio_o[0] && output_ratio_o <= 8'h80))
      else $error("Output ratio not one or even up to 128");

   a_alt_even: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      alt_output_ratio_o == 8'h01
      || (!alt_output_ratio_o[0] && alt_output_ratio_o <= 8'h80))
      else $error("Alternate ratio not one or even up to 128");

   a_divider_apply: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      apply
      |=> output_ratio_o == $past(out_ratio_dec))
      else $error("Output ratio not applied with the new frequency");

   a_hs_legal: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      high_speed_ratio_o inside {4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hb})
      else $error("High-speed ratio outside the legal set");

   a_alt_fields: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      reg_we_i && reg_addr_i == `OFC_OFF_ALT_LOW
      |=> alt_multiplier_top_o == $past(reg_wdata_i[5:0]))
      else $error("Alternate multiplier top not taken from offset 14");

   a_flag_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      new_frequency_flag_o && !synthesizer_hold_o && !reg_we_i
      |=> !new_frequency_flag_o)
      else $error("New-frequency flag did not clear on apply");

   a_freeze_mult: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      state_reg.freeze_mult && !new_frequency_flag_o
      |=> $stable(multiplier_word_o))
      else $error("Multiplier changed while frozen");

   a_hold_stable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      synthesizer_hold_o |=> $stable(output_ratio_o) && $stable(multiplier_word_o))
      else $error("Configuration changed while synthesizer held");

endmodule

// *** ofc_consts.svh ***
// Constants for the oscillator frequency configuration registers
`ifndef OFC_CONSTS_SVH
`define OFC_CONSTS_SVH

// ==========================================================
// Register offsets
`define OFC_OFF_DIV_HIGH      8'h07
`define OFC_OFF_DIV_LOW       8'h08
`define OFC_OFF_RATIO_31_24   8'h09
`define OFC_OFF_RATIO_23_16   8'h0a
`define OFC_OFF_RATIO_15_8    8'h0b
`define OFC_OFF_RATIO_7_0     8'h0c
`define OFC_OFF_ALT_SPEED     8'h0d
`define OFC_OFF_ALT_LOW       8'h0e
`define OFC_OFF_CONTROL       8'h87
`define OFC_OFF_HOLD          8'h89

// ==========================================================
// Field positions
`define OFC_BIT_NEW_FREQ      6
`define OFC_BIT_FREEZE_MULT   5
`define OFC_BIT_HOLD          4

// ==========================================================
// Reset values
`define OFC_RST_BYTE          8'h00
`define OFC_RST_MULT          38'h00_0000_0000
`define OFC_RST_HS_RATIO      4'h4
`define OFC_RST_OUT_RATIO     8'h01

// ==========================================================
// Divider decode values
`define OFC_HS_BASE           4'h4
`define OFC_HS_CODE_NINE      3'h5
`define OFC_HS_CODE_ELEVEN    3'h7
`define OFC_HS_RATIO_NINE     4'h9
`define OFC_HS_RATIO_ELEVEN   4'hb
`define OFC_HS_RATIO_NONE     4'h0

`endif

// *** ofc_pkg.sv ***
// Types for the oscillator frequency configuration registers
package ofc_pkg;

   // ==========================================================
   // Number of configuration bytes from offset 7 to offset 14
   localparam int CFG_BYTES = 8;

   // ==========================================================
   // Whole state of the register bank
   typedef struct packed {
      logic [CFG_BYTES-1:0][7:0] cfg;
      logic                      new_freq;
      logic                      freeze_mult;
      logic                      hold;
      logic [37:0]               mult_applied;
      logic [3:0]                hs_ratio;
      logic [7:0]                out_ratio;
      logic [3:0]                alt_hs_ratio;
      logic [7:0]                alt_out_ratio;
      logic [7:0]                rdata;
   } ofc_state_type;

endpackage

// *** ofc_divider_decode.sv ***
// Decoder from divider codes to division ratios
`timescale 1ns/1ps
`include "ofc_consts.svh"

module ofc_divider_decode (
   // Codes
   input  wire logic [2:0] hs_code_i,
   input  wire logic [6:0] out_code_i,
   // Ratios
   output logic      [3:0] hs_ratio_o,
   output logic            hs_legal_o,
   output logic      [7:0] out_ratio_o
);

   // ==========================================================
   // High-speed divider
   always_comb begin
      hs_legal_o = 1'b1;
      hs_ratio_o = `OFC_HS_BASE + {1'b0, hs_code_i};
      if (hs_code_i == `OFC_HS_CODE_NINE) begin
         hs_ratio_o = `OFC_HS_RATIO_NINE;
      end else if (hs_code_i == `OFC_HS_CODE_ELEVEN) begin
         hs_ratio_o = `OFC_HS_RATIO_ELEVEN;
      end else if (hs_code_i[2]) begin
         hs_ratio_o = `OFC_HS_RATIO_NONE;
         hs_legal_o = 1'b0;
      end
   end

   // ==========================================================
   // Output divider: code plus one, odd ratios above one rounded up
   always_comb begin
      out_ratio_o = {1'b0, out_code_i} + 8'h01;
      if (out_code_i != 7'h00 && out_ratio_o[0]) begin
         out_ratio_o = out_ratio_o + 8'h01;
      end
   end

endmodule

// *** ofc_host_model.sv ***
// Host model that programs the register bank one byte at a time
`timescale 1ns/1ps

module ofc_host_model (
   // Clock
   input  wire logic       clk_i,
   // Register port
   output logic      [7:0] reg_addr_o,
   output logic            reg_we_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_re_o,
   input  wire logic [7:0] reg_rdata_i
);
   initial begin
      reg_addr_o <= 8'h00;
      reg_we_o <= 1'b0;
      reg_wdata_o <= 8'h00;
      reg_re_o <= 1'b0;
   end

   // ==========================================================
   // Byte write, codes passed on exactly as the caller gives them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_we_o <= 1'b1;
      @(posedge clk_i);
      reg_we_o <= 1'b0;
      reg_wdata_o <= ~d;
      reg_addr_o <= ~a;
   endtask

   // ==========================================================
   // Byte read, data taken at the edge after the one that samples the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_re_o <= 1'b1;
      @(posedge clk_i);
      reg_re_o <= 1'b0;
      reg_addr_o <= ~a;
      @(posedge clk_i);
      d = reg_rdata_i;
   endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the frequency configuration registers
`timescale 1ns/1ps

module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        reg_we, reg_re;
   logic [37:0] mult_w;
   logic [3:0]  hs_r, alt_hs_r;
   logic [7:0]  out_r, alt_out_r;
   logic [5:0]  alt_top;
   logic        flag, hold;
   int          bad_count = 0;
   int          tests_run = 0;

   always #12.5 clk_i = ~clk_i;

   ofc_freq_regs i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr),
      .reg_we_i(reg_we), .reg_wdata_i(reg_wdata), .reg_re_i(reg_re),
      .reg_rdata_o(reg_rdata), .multiplier_word_o(mult_w), .high_speed_ratio_o(hs_r),
      .output_ratio_o(out_r), .alt_high_speed_ratio_o(alt_hs_r),
      .alt_output_ratio_o(alt_out_r), .alt_multiplier_top_o(alt_top),
      .new_frequency_flag_o(flag), .synthesizer_hold_o(hold));

   ofc_host_model h (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_we_o(reg_we),
      .reg_wdata_o(reg_wdata), .reg_re_o(reg_re), .reg_rdata_i(reg_rdata));

   // ==========================================================
   // Expectations
   function automatic logic [7:0] exp_out(input logic [6:0] c);
      if (c == 7'h00) return 8'h01;
      return c[0] ? {1'b0, c} + 8'h01 : {1'b0, c} + 8'h02;
   endfunction

   function automatic logic [3:0] exp_hs(input logic [2:0] c, input logic [3:0] p);
      case (c)
         3'h4, 3'h6: return p;
         3'h5: return 4'h9;
         3'h7: return 4'hb;
         default: return 4'h4 + {1'b0, c};
      endcase
   endfunction

   // ==========================================================
   // Helpers
   task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic results;
      $display("counts: tests_run=%0d bad_count=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      results();
   end

   // ==========================================================
   // Tests
   initial begin
      logic [37:0] m;
      logic [6:0]  c, ac;
      logic [2:0]  hc, ahc;
      logic [3:0]  ph, pah;
      logic [7:0]  po;
      logic [7:0]  d;
      logic [6:0]  corner [4];
      corner = '{7'h00, 7'h01, 7'h02, 7'h7f};
      void'($urandom(32'h3b922616));
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      settle();
      chk("mult_rst", 40'h0, 40'(mult_w));
      chk("hs_rst", 40'h4, 40'(hs_r));
      chk("out_rst", 40'h1, 40'(out_r));
      ph = 4'h4;
      pah = 4'h4;
      po = 8'h01;
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         m = 38'({$urandom, $urandom});
         c = (i < 4) ? corner[i] : 7'($urandom);
         ac = ~c;
         hc = 3'(i);
         ahc = 3'(i + 3);
         h.wr(8'h07, {hc, c[6:2]});
         h.wr(8'h08, {c[1:0], m[37:32]});
         h.wr(8'h09, m[31:24]);
         h.wr(8'h0a, m[23:16]);
         h.wr(8'h0b, m[15:8]);
         h.wr(8'h0c, m[7:0]);
         h.wr(8'h0d, {ahc, ac[6:2]});
         h.wr(8'h0e, {ac[1:0], ~m[37:32]});
         settle();
         chk("mult", {2'b0, m}, 40'(mult_w));
         chk("out_held", 40'(po), 40'(out_r));
         h.rd(8'h08, d);
         chk("rd8", {32'h0, c[1:0], m[37:32]}, 40'(d));
         h.wr(8'h87, 8'h40);
         #1 chk("flag_set", 40'h1, 40'(flag));
         @(posedge clk_i);
         #1 chk("flag_clr", 40'h0, 40'(flag));
         ph = exp_hs(hc, ph);
         pah = exp_hs(ahc, pah);
         po = exp_out(c);
         chk("out_ratio", 40'(po), 40'(out_r));
         chk("hs_ratio", 40'(ph), 40'(hs_r));
         chk("alt_out", 40'(exp_out(ac)), 40'(alt_out_r));
         chk("alt_hs", 40'(pah), 40'(alt_hs_r));
         chk("alt_top", {34'h0, ~m[37:32]}, 40'(alt_top));
      end
      $display("test dividers done");
      h.wr(8'h87, 8'h20);
      h.wr(8'h0c, ~m[7:0]);
      settle();
      chk("frozen", {2'b0, m}, 40'(mult_w));
      h.rd(8'h87, d);
      chk("rd135", 40'h20, 40'(d));
      h.wr(8'h87, 8'h00);
      settle();
      chk("thawed", {2'b0, m[37:8], ~m[7:0]}, 40'(mult_w));
      $display("test freeze done");
      h.wr(8'h89, 8'h10);
      h.wr(8'h07, 8'h20);
      h.wr(8'h87, 8'h40);
      settle();
      chk("hold_pin", 40'h1, 40'(hold));
      chk("hold_flag", 40'h1, 40'(flag));
      chk("hold_hs", 40'(ph), 40'(hs_r));
      chk("hold_out", 40'(po), 40'(out_r));
      h.rd(8'h89, d);
      chk("rd137", 40'h10, 40'(d));
      h.wr(8'h89, 8'h00);
      settle();
      chk("rel_flag", 40'h0, 40'(flag));
      chk("rel_hs", 40'h5, 40'(hs_r));
      $display("test hold done");
      h.wr(8'h20, 8'hff);
      h.rd(8'h20, d);
      chk("unmapped", 40'h0, 40'(d));
      $display("test unmapped done");
      results();
   end
endmodule
